/* File: inc/epd_regs.svh */
`ifndef EPD_REGS_SVH
`define EPD_REGS_SVH
// position counter and long position widths
`define EPD_POS_W 16
`define EPD_LPOS_W 32
// edge-capture channels and timebase width
`define EPD_NCH 4
`define EPD_TB_W 16
// queue depth and depth index width
`define EPD_QDEPTH 8
`define EPD_QAW 3
// state time: 167 ns at 12 MHz, as cycles of the 5 ns clock (rounded down)
`define EPD_STATE_NS 167
`define EPD_CLK_NS 5
`define EPD_STATE_CYC (`EPD_STATE_NS / `EPD_CLK_NS)
`define EPD_ST_W 6
// holding register reload delay in state times
`define EPD_RELOAD_ST 8
`define EPD_RELOAD_CYC (`EPD_RELOAD_ST * `EPD_STATE_CYC)
`define EPD_RL_W 9
// pending-data and queue-full bit positions in the capture status byte
`define EPD_PEND_BIT 7
`define EPD_FULL_BIT 0
// pwm counter width
`define EPD_PWM_W 8
`endif

/* File: inc/epd_pkg.sv */
`include "epd_regs.svh"
package epd_pkg;
  // one captured edge: channel mask, direction mask and timestamp
  typedef struct packed {
    logic [`EPD_NCH-1:0] chan;
    logic [`EPD_NCH-1:0] dir;
    logic [`EPD_TB_W-1:0] stamp;
  } epd_cap_t;
  // motor drive pins
  typedef struct packed {
    logic power_n;
    logic polarity;
  } epd_drive_t;
endpackage

/* File: logic/epd_cap_mem.sv */
`include "epd_regs.svh"
// small capture queue; read data leaves from a register
module epd_cap_mem
  import epd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire epd_cap_t wr_data,
  input wire logic rd_en,
  output epd_cap_t rd_data,
  output logic full,
  output logic empty
);
  epd_cap_t mem_r [`EPD_QDEPTH];
  logic [`EPD_QAW:0] wp_r;
  logic [`EPD_QAW:0] rp_r;
  wire do_wr = wr_en && !full;
  wire do_rd = rd_en && !empty;
  assign full = (wp_r[`EPD_QAW] != rp_r[`EPD_QAW]) &&
                (wp_r[`EPD_QAW-1:0] == rp_r[`EPD_QAW-1:0]);
  assign empty = (wp_r == rp_r);
  // storage carries no reset; pointers and the read register get a defined start
  always_ff @(posedge ref_clk) begin
    if (do_wr) mem_r[wp_r[`EPD_QAW-1:0]] <= wr_data;
  end
  // pointers and registered read port
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      rd_data <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
        rd_data <= mem_r[rp_r[`EPD_QAW-1:0]];
      end
    end
  end
endmodule // epd_cap_mem

/* File: logic/epd_pwm.sv */
`include "epd_regs.svh"
// 8-bit pwm: high at zero, low at compare
module epd_pwm
  import epd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic st_tick,
  input wire logic prescale,
  input wire logic [`EPD_PWM_W-1:0] compare,
  output logic pwm_out,
  output logic [`EPD_PWM_W-1:0] count
);
  logic [`EPD_PWM_W-1:0] count_r;
  logic half_r;
  // prescaler lets only every second state time through
  wire adv = st_tick && (!prescale || half_r);
  assign count = count_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      half_r <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      if (st_tick) half_r <= ~half_r;
      if (adv) count_r <= count_r + 1'b1;
      // zero sets, compare clears: duty is compare/256; compare 0 gives low
      if (count_r == compare) pwm_out <= 1'b0;
      else if (count_r == '0) pwm_out <= 1'b1;
    end
  end
endmodule // epd_pwm

/* File: logic/epd_top.sv */
`include "epd_regs.svh"
module epd_top
  import epd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic step_in,
  input wire logic count_direction,
  input wire logic sample_start,
  input wire logic ovf_clear,
  input wire logic [`EPD_NCH-1:0] cap_step,
  input wire logic [`EPD_NCH-1:0] cap_dir,
  input wire logic cap_read,
  input wire logic pwm_prescale,
  input wire logic [`EPD_PWM_W-1:0] pwm_compare,
  input wire logic motor_dir,
  output logic [`EPD_POS_W-1:0] quad_position_counter,
  output logic [`EPD_LPOS_W-1:0] position_r,
  output logic ovf_irq_r,
  output logic [`EPD_LPOS_W-1:0] chan_pos_r [`EPD_NCH],
  output logic [`EPD_TB_W-1:0] free_running_timebase,
  output epd_cap_t cap_hold_r,
  output logic [`EPD_PWM_W-1:0] capture_status,
  output epd_drive_t drive_r
);
  // three-stage synchronisers for step_in, count_direction, cap_step and cap_dir
  logic [2:0] step_s_r;
  logic [2:0] dir_s_r;
  logic [2:0] cap_s_r [`EPD_NCH];
  logic [2:0] cdir_s_r [`EPD_NCH];
  logic step_q_r;
  logic dir_q_r;
  logic [`EPD_NCH-1:0] cap_q_r;
  logic [`EPD_NCH-1:0] cdir_q_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      step_s_r <= '0;
      dir_s_r <= '0;
      step_q_r <= 1'b0;
      dir_q_r <= 1'b0;
    end else begin
      step_s_r <= {step_s_r[1:0], step_in};
      dir_s_r <= {dir_s_r[1:0], count_direction};
      // a change counts once stages two and three agree
      if (step_s_r[1] == step_s_r[2]) step_q_r <= step_s_r[2];
      if (dir_s_r[1] == dir_s_r[2]) dir_q_r <= dir_s_r[2];
    end
  end
  genvar g;
  generate
    for (g = 0; g < `EPD_NCH; g++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cap_s_r[g] <= '0;
          cdir_s_r[g] <= '0;
          cap_q_r[g] <= 1'b0;
          cdir_q_r[g] <= 1'b0;
        end else begin
          cap_s_r[g] <= {cap_s_r[g][1:0], cap_step[g]};
          cdir_s_r[g] <= {cdir_s_r[g][1:0], cap_dir[g]};
          if (cap_s_r[g][1] == cap_s_r[g][2]) cap_q_r[g] <= cap_s_r[g][2];
          if (cdir_s_r[g][1] == cdir_s_r[g][2])
            cdir_q_r[g] <= cdir_s_r[g][2];
        end
      end
    end
  endgenerate

  // state-time tick; the encoder may step once per tick at most
  logic [`EPD_ST_W-1:0] st_cnt_r;
  wire st_tick = (st_cnt_r == `EPD_ST_W'(`EPD_STATE_CYC - 1));
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) st_cnt_r <= '0;
    else st_cnt_r <= st_tick ? '0 : st_cnt_r + 1'b1;
  end

  // counter: each step edge counts; dir picks up or down
  logic step_d_r;
  logic [`EPD_POS_W-1:0] cnt_r;
  logic [`EPD_POS_W-1:0] samp_r;
  wire step_edge = step_q_r ^ step_d_r;
  wire [`EPD_POS_W-1:0] step_delta = !step_edge ? '0 :
    (dir_q_r ? `EPD_POS_W'(1) : '1);
  // overflow means a wrap between all-ones and zero in either direction
  wire cnt_ovf = step_edge &&
    (dir_q_r ? (cnt_r == '1) : (cnt_r == '0));
  // the sample is taken away, so edges in the same cycle still count
  wire [`EPD_POS_W-1:0] cnt_nxt = cnt_r + step_delta -
    (sample_start ? cnt_r : '0);
  wire [`EPD_LPOS_W-1:0] delta_ext =
    {{(`EPD_LPOS_W-`EPD_POS_W){cnt_r[`EPD_POS_W-1]}}, cnt_r};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      step_d_r <= 1'b0;
      cnt_r <= '0;
      samp_r <= '0;
      position_r <= '0;
      ovf_irq_r <= 1'b0;
    end else begin
      step_d_r <= step_q_r;
      cnt_r <= cnt_nxt;
      if (sample_start) begin
        samp_r <= cnt_r;
        position_r <= position_r + delta_ext;
      end
      // a new overflow beats a clear in the same cycle
      if (cnt_ovf) ovf_irq_r <= 1'b1;
      else if (ovf_clear) ovf_irq_r <= 1'b0;
    end
  end
  assign quad_position_counter = cnt_r;

  // free-running timebase advances every state time
  logic [`EPD_TB_W-1:0] tb_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) tb_r <= '0;
    else if (st_tick) tb_r <= tb_r + 1'b1;
  end
  assign free_running_timebase = tb_r;

  // edge capture on both edges, per channel positions
  logic [`EPD_NCH-1:0] cap_d_r;
  wire [`EPD_NCH-1:0] cap_edge = cap_q_r ^ cap_d_r;
  generate
    for (g = 0; g < `EPD_NCH; g++) begin : g_chan
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cap_d_r[g] <= 1'b0;
          chan_pos_r[g] <= '0;
        end else begin
          cap_d_r[g] <= cap_q_r[g];
          if (cap_edge[g])
            chan_pos_r[g] <= cdir_q_r[g] ?
              chan_pos_r[g] + 1'b1 : chan_pos_r[g] - 1'b1;
        end
      end
    end
  endgenerate

  // queue of captures; overflow of the queue drops new events
  epd_cap_t q_wr;
  epd_cap_t q_rd;
  logic q_full;
  logic q_empty;
  assign q_wr = '{chan: cap_edge, dir: cdir_q_r, stamp: tb_r};
  logic hold_v_r;
  logic [`EPD_RL_W-1:0] reload_r;
  logic load_pend_r;
  // reload only after the eight-state wait once the holder is free
  wire q_pop = !hold_v_r && !load_pend_r && !q_empty &&
    (reload_r == '0);
  epd_cap_mem u_mem (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(|cap_edge),
    .wr_data(q_wr),
    .rd_en(q_pop),
    .rd_data(q_rd),
    .full(q_full),
    .empty(q_empty)
  );
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_v_r <= 1'b0;
      load_pend_r <= 1'b0;
      reload_r <= '0;
      cap_hold_r <= '0;
    end else begin
      load_pend_r <= q_pop;
      if (load_pend_r) begin
        cap_hold_r <= q_rd;
        hold_v_r <= 1'b1;
      end else if (cap_read && hold_v_r) begin
        hold_v_r <= 1'b0;
        reload_r <= `EPD_RL_W'(`EPD_RELOAD_CYC);
      end else if (reload_r != '0) begin
        reload_r <= reload_r - 1'b1;
      end
    end
  end

  // status byte: bit 7 pending, bit 0 queue full
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) capture_status <= '0;
    else begin
      capture_status <= '0;
      capture_status[`EPD_PEND_BIT] <= hold_v_r || load_pend_r ||
        !q_empty;
      capture_status[`EPD_FULL_BIT] <= q_full;
    end
  end

  // pwm drives active-low power; polarity picks supply
  logic pwm_o;
  epd_pwm u_pwm (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .st_tick(st_tick),
    .prescale(pwm_prescale),
    .compare(pwm_compare),
    .pwm_out(pwm_o),
    .count()
  );
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) drive_r <= '{power_n: 1'b1, polarity: 1'b0};
    else drive_r <= '{power_n: pwm_o, polarity: motor_dir};
  end

  // cycles since the last accepted read; parked at all-ones when idle so
  // the very first pop after reset is not mistaken for an early reload
  logic [`EPD_RL_W-1:0] gap_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) gap_r <= '1;
    else if (cap_read && hold_v_r && !load_pend_r) gap_r <= '0;
    else if (gap_r != '1) gap_r <= gap_r + 1'b1;
  end

  // checks
  a_ovf_sticky: assert property (@(posedge ref_clk)
    disable iff (!rstn) cnt_ovf |=> ovf_irq_r)
    else $error("overflow not flagged");
  a_ovf_hold: assert property (@(posedge ref_clk)
    disable iff (!rstn) ovf_irq_r && !ovf_clear |=> ovf_irq_r)
    else $error("overflow flag dropped");
  a_cnt_up: assert property (@(posedge ref_clk)
    disable iff (!rstn) step_edge && dir_q_r && !sample_start |=>
    cnt_r == $past(cnt_r) + 16'h0001) else $error("count up wrong");
  a_cnt_dn: assert property (@(posedge ref_clk)
    disable iff (!rstn) step_edge && !dir_q_r && !sample_start |=>
    cnt_r == $past(cnt_r) - 16'h0001) else $error("count dn wrong");
  a_sample_sub: assert property (@(posedge ref_clk)
    disable iff (!rstn) sample_start && !step_edge |=> cnt_r == 16'h0000)
    else $error("sample not subtracted");
  a_samp_take: assert property (@(posedge ref_clk)
    disable iff (!rstn) sample_start |=> samp_r == $past(cnt_r))
    else $error("sample not taken");
  a_pos_ext: assert property (@(posedge ref_clk)
    disable iff (!rstn) sample_start |=> position_r == $past(position_r) +
    {{16{$past(cnt_r[15])}}, $past(cnt_r)})
    else $error("position add wrong");
  a_chan_step: assert property (@(posedge ref_clk)
    disable iff (!rstn) cap_edge[1] && cdir_q_r[1] |=>
    chan_pos_r[1] == $past(chan_pos_r[1]) + 32'h0000_0001)
    else $error("channel step wrong");
  a_pend_bit: assert property (@(posedge ref_clk)
    disable iff (!rstn) hold_v_r |=> capture_status[`EPD_PEND_BIT])
    else $error("pending not shown");
  a_reload_gap: assert property (@(posedge ref_clk)
    disable iff (!rstn) cap_read && hold_v_r && !load_pend_r |=>
    !q_pop [*8]) else $error("reloaded too soon");
  a_reload_wait: assert property (@(posedge ref_clk)
    disable iff (!rstn) q_pop |-> gap_r >= `EPD_RL_W'(`EPD_RELOAD_CYC))
    else $error("queue popped inside reload wait");
  c_ovf: cover property (@(posedge ref_clk) disable iff (!rstn) cnt_ovf);
  c_sample: cover property (@(posedge ref_clk) disable iff (!rstn)
    sample_start && step_edge);
  c_capread: cover property (@(posedge ref_clk) disable iff (!rstn)
    cap_read && hold_v_r);
endmodule // epd_top

/* File: tb/epd_enc_model.sv */
// encoder conditioning logic seen from the counter side
module epd_enc_model (
  input wire logic ref_clk,
  output logic step_out,
  output logic dir_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // toggles never come closer than one state time of 5 ns clocks
  localparam int GAP = 33;
  initial begin
    step_out = 1'b0;
    dir_out = 1'b1;
  end
  // direction settles a full state time before the first toggle
  task automatic move(input int n, input logic up);
    dir_out <= up;
    repeat (GAP) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      step_out <= ~step_out;
      repeat (GAP) @(posedge ref_clk);
    end
  endtask
endmodule // epd_enc_model

/* File: tb/epd_top_tb.sv */
`include "epd_regs.svh"
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end
module epd_top_tb
  import epd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, sample_start, ovf_clear, cap_read;
  logic pwm_prescale, motor_dir, step, dir, ovf;
  logic [3:0] cap_step, cap_dir;
  logic [7:0] pwm_compare, stat;
  logic [15:0] qpc, tbase;
  logic [31:0] pos;
  logic [31:0] chan_pos [4];
  epd_cap_t hold;
  epd_drive_t drv;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  epd_enc_model enc_u (.ref_clk(ref_clk), .step_out(step), .dir_out(dir));
  epd_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .step_in(step),
    .count_direction(dir), .sample_start(sample_start),
    .ovf_clear(ovf_clear), .cap_step(cap_step), .cap_dir(cap_dir),
    .cap_read(cap_read), .pwm_prescale(pwm_prescale),
    .pwm_compare(pwm_compare), .motor_dir(motor_dir),
    .quad_position_counter(qpc), .position_r(pos), .ovf_irq_r(ovf),
    .chan_pos_r(chan_pos), .free_running_timebase(tbase),
    .cap_hold_r(hold), .capture_status(stat), .drive_r(drv));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and still reaches the report
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic pulse_sample();
    sample_start <= 1'b1;
    tick(1);
    sample_start <= 1'b0;
    tick(2);
  endtask
  // a reversal mid-run must net out both ways
  task automatic t_count();
    enc_u.move(5, 1'b1);
    enc_u.move(2, 1'b0);
    tick(8);
    `CHK("qpc", 16'h0003, qpc)
  endtask
  // underflow through zero, then sign extension of a negative delta
  task automatic t_sample();
    pulse_sample();
    `CHK("pos", 32'h0000_0003, pos)
    `CHK("qpc0", 16'h0000, qpc)
    enc_u.move(5, 1'b0);
    `CHK("wrap", 16'hFFFB, qpc)
    `CHK("ovf", 1'b1, ovf)
    tick(20);
    `CHK("ovf_hold", 1'b1, ovf)
    pulse_sample();
    `CHK("pos_neg", 32'hFFFF_FFFE, pos)
    ovf_clear <= 1'b1;
    tick(1);
    ovf_clear <= 1'b0;
    tick(2);
    `CHK("ovf_clr", 1'b0, ovf)
  endtask
  // two channels, opposite directions, drained by two reads
  task automatic t_capture();
    logic [15:0] t0;
    cap_dir <= 4'b0010;
    tick(2);
    t0 = tbase;
    cap_step <= 4'b0010;
    tick(8);
    cap_step <= 4'b0110;
    tick(8);
    `CHK("ch1", 32'h0000_0001, chan_pos[1])
    `CHK("ch2", 32'hFFFF_FFFF, chan_pos[2])
    `CHK("ch0", 32'h0000_0000, chan_pos[0])
    `CHK("ch3", 32'h0000_0000, chan_pos[3])
    `CHK("pend", 1'b1, stat[7])
    `CHK("chan", 4'b0010, hold.chan)
    `CHK("dir", 4'b0010, hold.dir)
    `CHK("stamp", 1'b1, (hold.stamp - t0) <= 16'h0001)
    cap_read <= 1'b1;
    tick(1);
    cap_read <= 1'b0;
    tick(`EPD_RELOAD_CYC + 4);
    `CHK("chan2", 4'b0100, hold.chan)
    `CHK("pend2", 1'b1, stat[7])
    cap_read <= 1'b1;
    tick(1);
    cap_read <= 1'b0;
    tick(`EPD_RELOAD_CYC + 4);
    `CHK("drained", 1'b0, stat[7])
  endtask
  // timebase steps once per state time; polarity follows the request
  task automatic t_drive();
    logic [15:0] t1;
    t1 = tbase;
    tick(4 * `EPD_STATE_CYC);
    `CHK("tbase", 16'h0004, tbase - t1)
    motor_dir <= 1'b1;
    tick(3);
    `CHK("pol1", 1'b1, drv.polarity)
    motor_dir <= 1'b0;
    tick(3);
    `CHK("pol0", 1'b0, drv.polarity)
  endtask
  // high time over one whole period, after one period to settle
  task automatic t_pwm();
    logic [7:0] cv [4] = '{8'h40, 8'hFF, 8'h80, 8'h00};
    logic pv [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int per, hi;
    for (int k = 0; k < 4; k++) begin
      pwm_compare <= cv[k];
      pwm_prescale <= pv[k];
      per = 256 * `EPD_STATE_CYC * (pv[k] + 1);
      hi = 0;
      tick(per);
      for (int i = 0; i < per; i++) begin
        @(posedge ref_clk);
        if (drv.power_n === 1'b1) hi++;
      end
      `CHK("hi", cv[k] * per / 256, hi)
    end
  endtask
  initial begin
    rstn = 1'b0;
    sample_start = 1'b0;
    ovf_clear = 1'b0;
    cap_read = 1'b0;
    cap_step = 4'h0;
    cap_dir = 4'h0;
    pwm_prescale = 1'b0;
    pwm_compare = 8'h00;
    motor_dir = 1'b0;
    tick(3);
    `CHK("rst_qpc", 16'h0000, qpc)
    `CHK("rst_pwr", 1'b1, drv.power_n)
    rstn <= 1'b1;
    tick(4);
    t_count();
    t_sample();
    t_capture();
    t_drive();
    t_pwm();
    print_verdict();
  end
endmodule // epd_top_tb
